// *** hdl/lcm_regs.sv ***
// Register access over AXI4-Lite was left to the implementer.
`timescale 1ns/1ps
//
// Behaviour
// - segment lines per digit equals field plus one
// - bits 31:30 pick character mapping frame counter
// - start field gives first segment line index
// - mode bit: 0 sequential, 1 scrolling
// - six-bit digits per row field
// - common lines per row equals field plus one
// - bit mapping size is writes per symbol
// - bits 1:0 pick bit mapping frame counter
// - data bits: 1 energized, 0 transparent
// - mask bit 1 blocks matching data bit
// - three-bit common index selects common line
// - six-bit segment index selects segment line
module lcm_regs
    import lcm_pkg::*;
#(
    parameter int FIFO_DEPTH = 16,
    parameter int NUM_SEG = 64,
    parameter int NUM_COM = 8
) (
    // Clock and reset.
    input wire logic core_clk,
    input wire logic arst_n,
    // AXI4-Lite write address and data.
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    // AXI4-Lite write response.
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    output logic [1:0] s_axi_bresp,
    // AXI4-Lite read.
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    input wire logic [7:0] s_axi_araddr,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    // Decoded configuration for the automated mapper.
    output lcm_cfg_t map_cfg,
    // Display memory: one row of segment bits per common line.
    output logic [NUM_SEG-1:0] disp_mem [NUM_COM]
);
    // All control state of the slave.
    typedef struct packed {
        logic aw_held;
        logic awready;
        logic [7:0] aw_addr;
        logic wready;
        logic w_held;
        logic [31:0] w_data;
        logic [3:0] w_strb;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
        logic [31:0] acm_cfg;
        logic [7:0] abm_cfg;
        logic [23:0] mask;
        logic [15:0] index;
        logic [7:0] char_cfg;
        logic [7:0] step_count;
        lcm_cfg_t cfg;
    } lcm_st_t;

    lcm_st_t st, next_st;
    logic do_write, do_read, fifo_in_ready, upd_valid;
    logic [31:0] wmask;
    lcm_upd_t upd_in, upd_out;

    // A write completes only when both halves are held and no response is pending.
    // Data writes also need FIFO room, so a full FIFO back-pressures the bus.
    always_comb begin
        wmask = {{8{st.w_strb[3]}}, {8{st.w_strb[2]}}, {8{st.w_strb[1]}},
                 {8{st.w_strb[0]}}};
        do_write = st.aw_held && st.w_held && !st.bvalid
                   && ((st.aw_addr != LCM_OFF_SEG_DATA) || fifo_in_ready);
        do_read = s_axi_arvalid && st.arready;
    end

    // The masked update is queued with the index captured at write time.
    always_comb begin
        upd_in.com = st.index[LCM_IDX_COM_LSB +: 3];
        upd_in.seg = st.index[LCM_IDX_SEG_LSB +: 6];
        upd_in.data = st.w_data[23:0];
        upd_in.mask = st.mask;
    end

    lcm_fifo #(
        .WIDTH(LCM_UPD_W),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .core_clk(core_clk),
        .arst_n(arst_n),
        .in_valid(do_write && (st.aw_addr == LCM_OFF_SEG_DATA)),
        .in_ready(fifo_in_ready),
        .in_data(upd_in),
        .out_valid(upd_valid),
        .out_ready(1'b1),
        .out_data(upd_out)
    );

    always_comb begin
        next_st = st;
        // Address and data are accepted independently, in either order.
        if (s_axi_awvalid && !st.aw_held) begin
            next_st.aw_held = 1'b1;
            next_st.aw_addr = s_axi_awaddr;
        end
        if (s_axi_wvalid && !st.w_held) begin
            next_st.w_held = 1'b1;
            next_st.w_data = s_axi_wdata;
            next_st.w_strb = s_axi_wstrb;
        end
        if (st.bvalid && s_axi_bready) begin
            next_st.bvalid = 1'b0;
        end
        if (do_write) begin
            next_st.aw_held = 1'b0;
            next_st.w_held = 1'b0;
            next_st.bvalid = 1'b1;
            next_st.bresp = LCM_RESP_OKAY;
            case (st.aw_addr)
                LCM_OFF_CHAR_CFG: begin
                    next_st.char_cfg = (st.char_cfg & ~(wmask[7:0] & LCM_CCFG_WMASK))
                        | (st.w_data[7:0] & wmask[7:0] & LCM_CCFG_WMASK);
                end
                LCM_OFF_ACM_CFG: begin
                    next_st.acm_cfg = (st.acm_cfg & ~(wmask & LCM_ACM_WMASK))
                        | (st.w_data & wmask & LCM_ACM_WMASK);
                    next_st.step_count = '0;
                end
                LCM_OFF_ABM_CFG: begin
                    next_st.abm_cfg = (st.abm_cfg & ~wmask[7:0])
                        | (st.w_data[7:0] & wmask[7:0]);
                end
                LCM_OFF_SEG_DATA: begin
                end
                LCM_OFF_DATA_MASK: begin
                    next_st.mask = (st.mask & ~wmask[23:0]) | (st.w_data[23:0] & wmask[23:0]);
                end
                LCM_OFF_POS_INDEX: begin
                    next_st.index = (st.index & ~(wmask[15:0] & LCM_IDX_WMASK))
                        | (st.w_data[15:0] & wmask[15:0] & LCM_IDX_WMASK);
                end
                default: begin
                    next_st.bresp = LCM_RESP_SLVERR;
                end
            endcase
        end
        // Reads take one cycle of address, one of data; the data register reads zero.
        if (st.rvalid && s_axi_rready) begin
            next_st.rvalid = 1'b0;
            next_st.arready = 1'b1;
        end
        if (do_read) begin
            next_st.arready = 1'b0;
            next_st.rvalid = 1'b1;
            next_st.rresp = LCM_RESP_OKAY;
            case (s_axi_araddr)
                LCM_OFF_CHAR_CFG: next_st.rdata = {24'h000000, st.char_cfg};
                LCM_OFF_ACM_CFG: next_st.rdata = st.acm_cfg;
                LCM_OFF_ABM_CFG: next_st.rdata = {24'h000000, st.abm_cfg};
                LCM_OFF_SEG_DATA: next_st.rdata = 32'h00000000;
                LCM_OFF_DATA_MASK: next_st.rdata = {8'h00, st.mask};
                LCM_OFF_POS_INDEX: next_st.rdata = {16'h0000, st.index};
                default: begin
                    next_st.rdata = 32'h00000000;
                    next_st.rresp = LCM_RESP_SLVERR;
                end
            endcase
        end
        // Ready flags are kept in flops so the bus sees no logic after a register.
        // They follow the next held flags, so they add no cycle to a transfer.
        next_st.awready = !next_st.aw_held;
        next_st.wready = !next_st.w_held;
        // Decoded fields; the m1 counts are stored plus one for direct use.
        next_st.cfg.char_fc_sel = st.acm_cfg[LCM_ACM_FCS_LSB +: 2];
        next_st.cfg.first_segment_line = st.acm_cfg[LCM_ACM_FIRST_SEGMENT_LINE_LSB +: 6];
        next_st.cfg.sequential_display = !st.acm_cfg[LCM_ACM_MODE_BIT];
        next_st.cfg.digits_per_row = st.acm_cfg[LCM_ACM_DIGITS_PER_ROW_LSB +: 6];
        next_st.cfg.scroll_steps = st.acm_cfg[LCM_ACM_STEPS_LSB +: 8];
        next_st.cfg.digit_count = st.acm_cfg[LCM_ACM_DIGIT_COUNT_LSB +: 4];
        next_st.cfg.common_lines = {1'b0, st.acm_cfg[LCM_ACM_COMMON_LINES_PER_ROW_M1_LSB +: 3]} + 4'h1;
        next_st.cfg.seg_lines = {1'b0, st.char_cfg[2:0]} + 4'h1;
        next_st.cfg.bit_map_size = st.abm_cfg[LCM_ABM_SIZE_LSB +: 6];
        next_st.cfg.bit_fc_sel = st.abm_cfg[LCM_ABM_FCS_LSB +: 2];
        // In scrolling mode each drained update counts one step, wrapping at the count.
        if (upd_valid && st.acm_cfg[LCM_ACM_MODE_BIT]) begin
            next_st.step_count = (st.step_count + 8'h01 >= st.cfg.scroll_steps)
                ? 8'h00 : st.step_count + 8'h01;
        end
    end

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            st <= '0;
            st.arready <= 1'b1;
            st.awready <= 1'b1;
            st.wready <= 1'b1;
            st.acm_cfg <= LCM_RST_ACM_CFG;
            st.abm_cfg <= LCM_RST_ABM_CFG;
            st.mask <= LCM_RST_MASK;
            st.index <= LCM_RST_INDEX;
            st.char_cfg <= LCM_RST_CHAR_CFG;
            st.cfg.common_lines <= 4'h1;
            st.cfg.seg_lines <= 4'h1;
            st.cfg.sequential_display <= 1'b1;
        end else begin
            st <= next_st;
        end
    end

    // Display memory: only unmasked bits of the indexed row change.
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            for (int c = 0; c < NUM_COM; c++) begin
                disp_mem[c] <= '0;
            end
        end else if (upd_valid) begin
            for (int b = 0; b < 24; b++) begin
                if (!upd_out.mask[b] && (int'(upd_out.seg) + b < NUM_SEG)
                    && (int'(upd_out.com) < NUM_COM)) begin
                    disp_mem[upd_out.com][int'(upd_out.seg) + b] <= upd_out.data[b];
                end
            end
        end
    end

    assign s_axi_awready = st.awready;
    assign s_axi_wready = st.wready;
    assign s_axi_bvalid = st.bvalid;
    assign s_axi_bresp = st.bresp;
    assign s_axi_arready = st.arready;
    assign s_axi_rvalid = st.rvalid;
    assign s_axi_rdata = st.rdata;
    assign s_axi_rresp = st.rresp;
    assign map_cfg = st.cfg;

    // Display memory follows the drained update at bit 0 and at bit 23.
    AST_MASKED_KEPT: assert property (@(posedge core_clk) disable iff (!arst_n)
        upd_valid && upd_out.mask[0] && (int'(upd_out.seg) < NUM_SEG)
        |=> disp_mem[$past(upd_out.com)][$past(upd_out.seg)]
            == $past(disp_mem[upd_out.com][upd_out.seg]))
        else $error("Masked segment bit changed.");
    AST_DATA_WRITTEN: assert property (@(posedge core_clk) disable iff (!arst_n)
        upd_valid && !upd_out.mask[0] && (int'(upd_out.seg) < NUM_SEG)
        |=> disp_mem[$past(upd_out.com)][$past(upd_out.seg)] == $past(upd_out.data[0]))
        else $error("Unmasked segment bit not written.");
    AST_TOP_BIT_WRITTEN: assert property (@(posedge core_clk) disable iff (!arst_n)
        upd_valid && !upd_out.mask[23] && (int'(upd_out.seg) + 23 < NUM_SEG)
        |=> disp_mem[$past(upd_out.com)][int'($past(upd_out.seg)) + 23]
            == $past(upd_out.data[23]))
        else $error("Unmasked top segment bit not written.");
    AST_TOP_BIT_KEPT: assert property (@(posedge core_clk) disable iff (!arst_n)
        upd_valid && upd_out.mask[23] && (int'(upd_out.seg) + 23 < NUM_SEG)
        |=> disp_mem[$past(upd_out.com)][int'($past(upd_out.seg)) + 23]
            == $past(disp_mem[upd_out.com][int'(upd_out.seg) + 23]))
        else $error("Masked top segment bit changed.");
    // The row after the indexed one stays put; this check assumes eight rows.
    AST_OTHER_ROW_KEPT: assert property (@(posedge core_clk) disable iff (!arst_n)
        upd_valid |=> disp_mem[$past(upd_out.com) + 3'h1]
            == $past(disp_mem[upd_out.com + 3'h1]))
        else $error("Display row outside the index changed.");
    AST_IDLE_MEM_KEPT: assert property (@(posedge core_clk) disable iff (!arst_n)
        !upd_valid |=> disp_mem[0] == $past(disp_mem[0]))
        else $error("Display memory changed with no update.");
    AST_DATA_QUEUED: assert property (@(posedge core_clk) disable iff (!arst_n)
        do_write && st.aw_addr == LCM_OFF_SEG_DATA
        |=> upd_valid && upd_out == $past(upd_in))
        else $error("Segment data update not queued.");
    AST_SEG_PLUS_ONE: assert property (@(posedge core_clk) disable iff (!arst_n)
        ##1 map_cfg.seg_lines == {1'b0, $past(st.char_cfg[2:0])} + 4'h1)
        else $error("Segment line count wrong.");
    AST_COM_PLUS_ONE: assert property (@(posedge core_clk) disable iff (!arst_n)
        ##1 map_cfg.common_lines == {1'b0, $past(st.acm_cfg[2:0])} + 4'h1)
        else $error("Common line count wrong.");
    AST_CHAR_FCS: assert property (@(posedge core_clk) disable iff (!arst_n)
        ##1 map_cfg.char_fc_sel == $past(st.acm_cfg[31:30]))
        else $error("Character frame counter select wrong.");
    AST_START_SEG: assert property (@(posedge core_clk) disable iff (!arst_n)
        ##1 map_cfg.first_segment_line == $past(st.acm_cfg[29:24]))
        else $error("Start segment line wrong.");
    AST_MODE: assert property (@(posedge core_clk) disable iff (!arst_n)
        ##1 map_cfg.sequential_display == !$past(st.acm_cfg[23]))
        else $error("Display mode wrong.");
    AST_ROW: assert property (@(posedge core_clk) disable iff (!arst_n)
        ##1 map_cfg.digits_per_row == $past(st.acm_cfg[21:16]))
        else $error("Digits per row wrong.");
    AST_STEPS: assert property (@(posedge core_clk) disable iff (!arst_n)
        ##1 map_cfg.scroll_steps == $past(st.acm_cfg[15:8]))
        else $error("Scroll step count wrong.");
    AST_DIGITS: assert property (@(posedge core_clk) disable iff (!arst_n)
        ##1 map_cfg.digit_count == $past(st.acm_cfg[7:4]))
        else $error("Digit count wrong.");
    AST_BIT_MAP: assert property (@(posedge core_clk) disable iff (!arst_n)
        ##1 {map_cfg.bit_map_size, map_cfg.bit_fc_sel} == $past(st.abm_cfg))
        else $error("Bit mapping configuration wrong.");
    // Full-word register writes land at once, with reserved bits cleared.
    AST_INDEX_WRITE: assert property (@(posedge core_clk) disable iff (!arst_n)
        do_write && st.aw_addr == LCM_OFF_POS_INDEX && st.w_strb == 4'hF
        |=> st.index == ($past(st.w_data[15:0]) & LCM_IDX_WMASK))
        else $error("Index register not written.");
    AST_ACM_WRITE: assert property (@(posedge core_clk) disable iff (!arst_n)
        do_write && st.aw_addr == LCM_OFF_ACM_CFG && st.w_strb == 4'hF
        |=> st.acm_cfg == ($past(st.w_data) & LCM_ACM_WMASK))
        else $error("Automated character configuration not written.");
    AST_ABM_WRITE: assert property (@(posedge core_clk) disable iff (!arst_n)
        do_write && st.aw_addr == LCM_OFF_ABM_CFG && st.w_strb == 4'hF
        |=> st.abm_cfg == $past(st.w_data[7:0]))
        else $error("Automated bit configuration not written.");
    AST_CHAR_WRITE: assert property (@(posedge core_clk) disable iff (!arst_n)
        do_write && st.aw_addr == LCM_OFF_CHAR_CFG && st.w_strb == 4'hF
        |=> st.char_cfg == ($past(st.w_data[7:0]) & LCM_CCFG_WMASK))
        else $error("Character configuration not written.");
    AST_MASK_WRITE: assert property (@(posedge core_clk) disable iff (!arst_n)
        do_write && st.aw_addr == LCM_OFF_DATA_MASK && st.w_strb == 4'hF
        |=> st.mask == $past(st.w_data[23:0]))
        else $error("Data mask not written.");
    // Read data reflect the registers as they stood when the address was taken.
    AST_MASK_READ: assert property (@(posedge core_clk) disable iff (!arst_n)
        do_read && s_axi_araddr == LCM_OFF_DATA_MASK
        |=> s_axi_rdata == {8'h00, $past(st.mask)})
        else $error("Data mask read wrong.");
    AST_INDEX_READ: assert property (@(posedge core_clk) disable iff (!arst_n)
        do_read && s_axi_araddr == LCM_OFF_POS_INDEX
        |=> s_axi_rdata == {16'h0000, $past(st.index)})
        else $error("Index read wrong.");
    AST_DATA_READS_ZERO: assert property (@(posedge core_clk) disable iff (!arst_n)
        do_read && s_axi_araddr == LCM_OFF_SEG_DATA
        |=> s_axi_rdata == 32'h00000000)
        else $error("Write-only data register read nonzero.");
endmodule // lcm_regs

// *** hdl/lcm_pkg.sv ***
package lcm_pkg;
    // Register byte offsets.
    localparam logic [7:0] LCM_OFF_CHAR_CFG = 8'h70;
    localparam logic [7:0] LCM_OFF_ACM_CFG = 8'h74;
    localparam logic [7:0] LCM_OFF_ABM_CFG = 8'h78;
    localparam logic [7:0] LCM_OFF_SEG_DATA = 8'h7C;
    localparam logic [7:0] LCM_OFF_DATA_MASK = 8'h80;
    localparam logic [7:0] LCM_OFF_POS_INDEX = 8'h84;
    // Reset values.
    localparam logic [31:0] LCM_RST_ACM_CFG = 32'h00000000;
    localparam logic [7:0] LCM_RST_ABM_CFG = 8'h00;
    localparam logic [23:0] LCM_RST_MASK = 24'h000000;
    localparam logic [15:0] LCM_RST_INDEX = 16'h0000;
    localparam logic [7:0] LCM_RST_CHAR_CFG = 8'h00;
    // Writable bits of each register.
    localparam logic [31:0] LCM_ACM_WMASK = 32'hFFBFFFF7;
    localparam logic [15:0] LCM_IDX_WMASK = 16'h073F;
    localparam logic [7:0] LCM_CCFG_WMASK = 8'h0F;
    // Field positions.
    localparam int LCM_ACM_FCS_LSB = 30;
    localparam int LCM_ACM_FIRST_SEGMENT_LINE_LSB = 24;
    localparam int LCM_ACM_MODE_BIT = 23;
    localparam int LCM_ACM_DIGITS_PER_ROW_LSB = 16;
    localparam int LCM_ACM_STEPS_LSB = 8;
    localparam int LCM_ACM_DIGIT_COUNT_LSB = 4;
    localparam int LCM_ACM_COMMON_LINES_PER_ROW_M1_LSB = 0;
    localparam int LCM_ABM_SIZE_LSB = 2;
    localparam int LCM_ABM_FCS_LSB = 0;
    localparam int LCM_IDX_COM_LSB = 8;
    localparam int LCM_IDX_SEG_LSB = 0;
    // AXI responses.
    localparam logic [1:0] LCM_RESP_OKAY = 2'h0;
    localparam logic [1:0] LCM_RESP_SLVERR = 2'h2;

    // One masked display memory update.
    typedef struct packed {
        logic [2:0] com;
        logic [5:0] seg;
        logic [23:0] data;
        logic [23:0] mask;
    } lcm_upd_t;
    localparam int LCM_UPD_W = $bits(lcm_upd_t);

    // Decoded automated mapping configuration.
    typedef struct packed {
        logic [1:0] char_fc_sel;
        logic [5:0] first_segment_line;
        logic sequential_display;
        logic [5:0] digits_per_row;
        logic [7:0] scroll_steps;
        logic [3:0] digit_count;
        logic [3:0] common_lines;
        logic [3:0] seg_lines;
        logic [5:0] bit_map_size;
        logic [1:0] bit_fc_sel;
    } lcm_cfg_t;
endpackage

// *** hdl/lcm_fifo.sv ***
`timescale 1ns/1ps
module lcm_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 16
) (
    // Clock and reset.
    input wire logic core_clk,
    input wire logic arst_n,
    // Fill side.
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    // Drain side.
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);

    typedef struct packed {
        logic [AW-1:0] wp;
        logic [AW-1:0] rp;
        logic [AW:0] cnt;
    } lcm_fifo_st_t;

    lcm_fifo_st_t st, next_st;
    logic [WIDTH-1:0] mem [DEPTH];
    logic push, pop;

    assign in_ready = (st.cnt != (AW+1)'(DEPTH));
    assign out_valid = (st.cnt != '0);
    assign out_data = mem[st.rp];
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;

    // Pointers wrap at DEPTH so any depth, not just powers of two, works.
    always_comb begin
        next_st = st;
        if (push) begin
            next_st.wp = (st.wp == AW'(DEPTH-1)) ? '0 : st.wp + 1'b1;
        end
        if (pop) begin
            next_st.rp = (st.rp == AW'(DEPTH-1)) ? '0 : st.rp + 1'b1;
        end
        next_st.cnt = st.cnt + (AW+1)'(push) - (AW+1)'(pop);
    end

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    // Storage carries no reset; entries are only read once written.
    always_ff @(posedge core_clk) begin
        if (push) begin
            mem[st.wp] <= in_data;
        end
    end
endmodule // lcm_fifo

// *** sim/lcm_regs_tb.sv ***
`timescale 1ns/1ps
module lcd_character_mapping_regs_tb_top import lcm_pkg::*; ;
    // Clock, reset and driven bus signals, all given a value at time zero.
    logic core_clk = 1'b0;
    logic arst_n = 1'b0;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h00000000;
    logic [3:0] s_axi_wstrb = 4'h0;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic [31:0] s_axi_rdata;
    lcm_cfg_t map_cfg;
    logic [63:0] disp_mem [8];
    logic [63:0] exp_mem [8];
    int num_errors = 0;
    int n_checks = 0;
    // Display update table: overlapping writes show that masked bits keep old values.
    logic [2:0] t_com [4] = '{3'h3, 3'h3, 3'h7, 3'h0};
    logic [5:0] t_seg [4] = '{6'h0A, 6'h0A, 6'h28, 6'h00};
    logic [23:0] t_dat [4] = '{24'hA5A5A5, 24'hFFFFFF, 24'h123456, 24'hFFFFFF};
    logic [23:0] t_msk [4] = '{24'h00FF00, 24'hF0000F, 24'h000000, 24'h800001};

    lcm_regs uut (.core_clk(core_clk), .arst_n(arst_n),
        .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
        .s_axi_awaddr(s_axi_awaddr), .s_axi_wvalid(s_axi_wvalid),
        .s_axi_wready(s_axi_wready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
        .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_bresp(s_axi_bresp),
        .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
        .s_axi_araddr(s_axi_araddr), .s_axi_rvalid(s_axi_rvalid),
        .s_axi_rready(s_axi_rready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
        .map_cfg(map_cfg), .disp_mem(disp_mem));

    // Free-running 10 MHz clock.
    initial begin
        forever #50 core_clk = ~core_clk;
    end

    // Prints the counts and the verdict, then ends the run.
    task automatic summarize;
        $display("checks %0d errors %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    task automatic chk32(input string name, input logic [31:0] exp, input logic [31:0] got);
        n_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("unexpected %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic chk64(input string name, input logic [63:0] exp, input logic [63:0] got);
        n_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("unexpected %s expected %h seen %h", name, exp, got);
        end
    endtask

    // One write; address and data are dropped each at its own acceptance edge.
    task automatic axi_write(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
                             output logic [1:0] resp);
        bit got;
        got = 0;
        resp = 2'h3;
        @(posedge core_clk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_wstrb <= s;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        for (int i = 0; i < 200 && !got; i++) begin
            @(posedge core_clk);
            if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
            if (s_axi_bvalid) begin
                resp = s_axi_bresp;
                got = 1;
            end
        end
        s_axi_bready <= 1'b0;
        if (!got) begin
            num_errors++;
            summarize();
        end
    endtask

    task automatic axi_read(input logic [7:0] a, output logic [31:0] d, output logic [1:0] resp);
        bit got;
        got = 0;
        d = 32'hFFFFFFFF;
        resp = 2'h3;
        @(posedge core_clk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        for (int i = 0; i < 200 && !got; i++) begin
            @(posedge core_clk);
            if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
            if (s_axi_rvalid) begin
                d = s_axi_rdata;
                resp = s_axi_rresp;
                got = 1;
            end
        end
        s_axi_rready <= 1'b0;
        if (!got) begin
            num_errors++;
            summarize();
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] eresp);
        logic [1:0] r;
        axi_write(a, d, 4'hF, r);
        chk32("write response", {30'h0, eresp}, {30'h0, r});
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] eresp);
        logic [31:0] d;
        logic [1:0] r;
        axi_read(a, d, r);
        chk32("read response", {30'h0, eresp}, {30'h0, r});
        chk32("read data", e, d);
    endtask

    // Reference model of one masked display update.
    task automatic apply(input int k);
        for (int b = 0; b < 24; b++) begin
            if (!t_msk[k][b] && (int'(t_seg[k]) + b) < 64) exp_mem[t_com[k]][t_seg[k] + b] = t_dat[k][b];
        end
    endtask

    initial begin
        logic [31:0] v;
        logic [1:0] r;
        for (int i = 0; i < 8; i++) exp_mem[i] = 64'h0;
        repeat (20) @(posedge core_clk);
        arst_n <= 1'b1;
        // Reset values and reset decode of the configuration.
        rd(LCM_OFF_ACM_CFG, 32'h00000000, LCM_RESP_OKAY);
        rd(LCM_OFF_ABM_CFG, 32'h00000000, LCM_RESP_OKAY);
        rd(LCM_OFF_DATA_MASK, 32'h00000000, LCM_RESP_OKAY);
        rd(LCM_OFF_POS_INDEX, 32'h00000000, LCM_RESP_OKAY);
        rd(LCM_OFF_CHAR_CFG, 32'h00000000, LCM_RESP_OKAY);
        chk32("seg lines", 32'h1, 32'(map_cfg.seg_lines));
        chk32("com lines", 32'h1, 32'(map_cfg.common_lines));
        chk32("sequential", 32'h1, 32'(map_cfg.sequential_display));
        // Frame counter codes 0 to 2 for character mapping; the mode bit alternates.
        for (int f = 0; f < 3; f++) begin
            v = {2'(f), 6'h2A, 1'(f), 1'b0, 6'h15, 8'h5A, 4'h3, 1'b0, 3'h5};
            wr(LCM_OFF_ACM_CFG, v, LCM_RESP_OKAY);
            repeat (2) @(posedge core_clk);
            chk32("char fc select", 32'(f), 32'(map_cfg.char_fc_sel));
            chk32("first segment line", 32'h2A, 32'(map_cfg.first_segment_line));
            chk32("sequential", 32'(f % 2 == 0), 32'(map_cfg.sequential_display));
            chk32("digits per row", 32'h15, 32'(map_cfg.digits_per_row));
            chk32("scroll steps", 32'h5A, 32'(map_cfg.scroll_steps));
            chk32("digit count", 32'h3, 32'(map_cfg.digit_count));
            chk32("com lines", 32'h6, 32'(map_cfg.common_lines));
            rd(LCM_OFF_ACM_CFG, v, LCM_RESP_OKAY);
        end
        // Reserved bits read as zero; only the strobed byte changes.
        wr(LCM_OFF_ACM_CFG, 32'hFFFFFFFF, LCM_RESP_OKAY);
        rd(LCM_OFF_ACM_CFG, 32'hFFBFFFF7, LCM_RESP_OKAY);
        chk32("com lines", 32'h8, 32'(map_cfg.common_lines));
        axi_write(LCM_OFF_ACM_CFG, 32'h00000000, 4'b1000, r);
        rd(LCM_OFF_ACM_CFG, 32'h00BFFFF7, LCM_RESP_OKAY);
        // Frame counter codes 0 to 2 for bit mapping, with a symbol size above one.
        for (int f = 0; f < 3; f++) begin
            wr(LCM_OFF_ABM_CFG, {24'h0, 6'h2B, 2'(f)}, LCM_RESP_OKAY);
            repeat (2) @(posedge core_clk);
            chk32("bit map size", 32'h2B, 32'(map_cfg.bit_map_size));
            chk32("bit fc select", 32'(f), 32'(map_cfg.bit_fc_sel));
            rd(LCM_OFF_ABM_CFG, {24'h0, 6'h2B, 2'(f)}, LCM_RESP_OKAY);
        end
        // Segment lines per digit at the top of its field and at 3, then the writable index bits.
        wr(LCM_OFF_CHAR_CFG, 32'h000000FF, LCM_RESP_OKAY);
        rd(LCM_OFF_CHAR_CFG, 32'h0000000F, LCM_RESP_OKAY);
        chk32("seg lines", 32'h8, 32'(map_cfg.seg_lines));
        wr(LCM_OFF_CHAR_CFG, 32'h00000002, LCM_RESP_OKAY);
        repeat (2) @(posedge core_clk);
        chk32("seg lines", 32'h3, 32'(map_cfg.seg_lines));
        wr(LCM_OFF_POS_INDEX, 32'h0000FFFF, LCM_RESP_OKAY);
        rd(LCM_OFF_POS_INDEX, 32'h0000073F, LCM_RESP_OKAY);
        // Masked display updates; every row is compared so stray bits show.
        for (int k = 0; k < 4; k++) begin
            wr(LCM_OFF_DATA_MASK, {8'h00, t_msk[k]}, LCM_RESP_OKAY);
            rd(LCM_OFF_DATA_MASK, {8'h00, t_msk[k]}, LCM_RESP_OKAY);
            wr(LCM_OFF_POS_INDEX, {21'h0, t_com[k], 2'h0, t_seg[k]}, LCM_RESP_OKAY);
            wr(LCM_OFF_SEG_DATA, {8'hFF, t_dat[k]}, LCM_RESP_OKAY);
            apply(k);
            repeat (3) @(posedge core_clk);
            for (int i = 0; i < 8; i++) chk64("display row", exp_mem[i], disp_mem[i]);
        end
        // The data register is write-only; unmapped places answer with an error.
        rd(LCM_OFF_SEG_DATA, 32'h00000000, LCM_RESP_OKAY);
        wr(8'h90, 32'h12345678, LCM_RESP_SLVERR);
        rd(8'h90, 32'h00000000, LCM_RESP_SLVERR);
        rd(LCM_OFF_POS_INDEX, {21'h0, t_com[3], 2'h0, t_seg[3]}, LCM_RESP_OKAY);
        summarize();
    end
endmodule // lcd_character_mapping_regs_tb_top
